// >>> hw/pinfn_pkg.sv
// pin function and gpio control: shared constants, field layouts, types
// assumes one core clock; the register port addresses registers by index
//
// Overview of operation
// - direction enable waits 0..15 programmed bit times before returning to receive
// - role bit 9 (default 1) puts receive toggle on pin nine, else gpio
// - role bit 8 (default 1) puts transmit toggle on pin eight, else gpio
// - role bit 7 (default 0) puts generated clock on pin six, else gpio
// - field 6:5 sets pin seven: gpio, enable on transmit, enable on match
// - bit 4 low: pin seven gpio; high: pin seven per 6:5; pin five follows 2:0 either way
// - bit 3 sets direction enable polarity: 0 active low, 1 active high
// - field 2:0: 000 gpio, 001 rts/cts on pins 5/4, 010 dtr/dsr on 2/3
// - field 2:0: 011 enable on transmit, 100 enable on match, on pin five
// - per gpio pin direction bit: 0 input, 1 output; alternate pins ignore it
// - write to output-set drives high each gpio output whose bit is one
// - output-set ignores alternate-role pins and gpio pins set as inputs
// - write to output-clear drives low gpio outputs whose bit is one
// - half duplex: receive input ignored while the uart transmits

package pinfn_pkg;

    // -------------------------------------------------------------------
    // register indices and reset values
    // -------------------------------------------------------------------
    localparam logic [7:0]  OFS_TURNAROUND = 8'h0b;
    localparam logic [7:0]  OFS_ROLE       = 8'h0c;
    localparam logic [7:0]  OFS_DIR        = 8'h0d;
    localparam logic [7:0]  OFS_SET        = 8'h0e;
    localparam logic [7:0]  OFS_CLEAR      = 8'h0f;
    localparam logic [7:0]  OFS_STATE      = 8'h10;
    localparam logic [3:0]  RST_TURNAROUND = 4'h0;
    localparam logic [9:0]  RST_ROLE       = 10'h300;
    localparam logic [9:0]  RST_DIR        = 10'h000;
    localparam logic [9:0]  RST_GPIO_OUT   = 10'h000;
    localparam int          NPINS          = 10;

    // -------------------------------------------------------------------
    // pin positions of alternate roles
    // -------------------------------------------------------------------
    localparam int PIN_DTR    = 2;
    localparam int PIN_DSR    = 3;
    localparam int PIN_CTS    = 4;
    localparam int PIN_RTS_DE = 5;
    localparam int PIN_CLK    = 6;
    localparam int PIN_DE     = 7;
    localparam int PIN_TXTOG  = 8;
    localparam int PIN_RXTOG  = 9;

    // -------------------------------------------------------------------
    // role register layout, low ten bits
    // -------------------------------------------------------------------
    typedef enum logic [2:0] {
        P5_GPIO     = 3'h0,
        P5_RTS_CTS  = 3'h1,
        P5_DTR_DSR  = 3'h2,
        P5_DE_TX    = 3'h3,
        P5_DE_MATCH = 3'h4
    } p5_role_t;

    typedef enum logic [1:0] {
        P7_GPIO     = 2'h0,
        P7_DE_TX    = 2'h1,
        P7_DE_MATCH = 2'h2
    } p7_role_t;

    typedef struct packed {
        logic     rx_tog;
        logic     tx_tog;
        logic     clk_en;
        p7_role_t p7_role;
        logic     p7_sel;
        logic     pol;
        p5_role_t p5_role;
    } role_reg_t;

    // turn-around sequencer states
    typedef enum logic [2:0] {
        TA_IDLE = 3'b001,
        TA_SEND = 3'b010,
        TA_HOLD = 3'b100
    } ta_state_t;

    // -------------------------------------------------------------------
    // carriers to and from the uart core
    // -------------------------------------------------------------------
    typedef struct packed {
        logic tx_busy;
        logic bit_tick;
        logic tx_char;
        logic rx_char;
        logic addr_match;
        logic rts_level;
        logic dtr_level;
        logic clk_gen;
        logic half_duplex;
    } uart_side_t;

    typedef struct packed {
        logic cts;
        logic dsr;
        logic rx_data;
    } flow_side_t;

endpackage : pinfn_pkg

// >>> hw/turnaround_timer.sv
// turn-around sequencer for the automatic transceiver direction enable
// assumes tx busy covers every bit including the final stop bit
`timescale 1ns/1ps
`default_nettype none

module turnaround_timer
    import pinfn_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       arst_n_i,
    input  wire logic       ce_i,
    input  wire logic       tx_busy_i,
    input  wire logic       bit_tick_i,
    input  wire logic [3:0] delay_i,
    output var  logic       de_o
);

    ta_state_t  state_q;
    ta_state_t  state_d;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;

    // next state; a new character during the hold re-arms transmit
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        case (state_q)
            TA_IDLE: begin
                if (tx_busy_i) begin
                    state_d = TA_SEND;
                end
            end
            TA_SEND: begin
                if (!tx_busy_i) begin
                    cnt_d   = delay_i;
                    state_d = (delay_i == 4'h0) ? TA_IDLE : TA_HOLD;
                end
            end
            TA_HOLD: begin
                if (tx_busy_i) begin
                    state_d = TA_SEND;
                end else if (bit_tick_i) begin
                    cnt_d = cnt_q - 4'h1;
                    if (cnt_q == 4'h1) begin
                        state_d = TA_IDLE;
                    end
                end
            end
            default: state_d = TA_IDLE;
        endcase
    end

    // state registers, frozen while ce is low
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q <= TA_IDLE;
            cnt_q   <= 4'h0;
        end else if (ce_i) begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    // enable held through transmit and the whole hold
    assign de_o = (state_q != TA_IDLE);

    // -------------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------------
    a_hold_load: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (ce_i && state_q == TA_SEND && !tx_busy_i && delay_i != 4'h0)
        |=> (state_q == TA_HOLD && cnt_q == $past(delay_i)))
        else $error("hold not loaded with delay");

    a_hold_zero: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (ce_i && state_q == TA_SEND && !tx_busy_i && delay_i == 4'h0)
        |=> !de_o)
        else $error("zero delay still held");

    a_hold_expire: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (ce_i && state_q == TA_HOLD && !tx_busy_i && bit_tick_i && cnt_q == 4'h1)
        |=> !de_o)
        else $error("enable held past last bit time");

    a_hold_stays: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (state_q == TA_HOLD && !bit_tick_i && !tx_busy_i) |=> de_o)
        else $error("enable dropped inside hold");

    c_hold_done: cover property (@(posedge clk_i) disable iff (!arst_n_i)
        state_q == TA_HOLD ##1 state_q == TA_IDLE);

endmodule : turnaround_timer

`default_nettype wire

// >>> hw/pin_function_ctrl.sv
// pin function and gpio control for one uart channel
// assumes uart-side inputs are on CLK_I; pin inputs are asynchronous
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module pin_function_ctrl
    import pinfn_pkg::*;
(
    input  wire logic             CLK_I,
    input  wire logic             ARST_N_I,
    input  wire logic             CE_I,
    input  wire logic [7:0]       REG_ADDR_I,
    input  wire logic [15:0]      REG_WDATA_I,
    input  wire logic             REG_WR_I,
    input  wire logic             REG_RD_I,
    output var  logic [15:0]      REG_RDATA_O,
    input  wire uart_side_t       UART_I,
    output var  flow_side_t       FLOW_O,
    input  wire logic             RX_SERIAL_I,
    input  wire logic [NPINS-1:0] PIN_I,
    output var  logic [NPINS-1:0] PIN_O,
    output var  logic [NPINS-1:0] PIN_OE_O
);

    // -------------------------------------------------------------------
    // registers and synchronisers
    // -------------------------------------------------------------------
    logic [3:0]       delay_q;
    role_reg_t        role_q;
    logic [NPINS-1:0] dir_q;
    logic [NPINS-1:0] gpio_q;
    logic [NPINS-1:0] gpio_d;
    logic             tx_tog_q;
    logic             rx_tog_q;
    logic [NPINS-1:0] pin_s1_q;
    logic [NPINS-1:0] pin_s2_q;
    logic             rx_s1_q;
    logic             rx_s2_q;
    logic [15:0]      rdata_d;
    logic [NPINS-1:0] alt_mask;
    logic [NPINS-1:0] alt_val;
    logic [NPINS-1:0] alt_oe;
    logic [NPINS-1:0] pin_d;
    logic [NPINS-1:0] oe_d;
    flow_side_t       flow_d;

    // -------------------------------------------------------------------
    // address decode
    // -------------------------------------------------------------------
    wire wr_delay = REG_WR_I && (REG_ADDR_I == OFS_TURNAROUND);
    wire wr_role  = REG_WR_I && (REG_ADDR_I == OFS_ROLE);
    wire wr_dir   = REG_WR_I && (REG_ADDR_I == OFS_DIR);
    wire wr_set   = REG_WR_I && (REG_ADDR_I == OFS_SET);
    wire wr_clear = REG_WR_I && (REG_ADDR_I == OFS_CLEAR);

    // only gpio pins set as outputs accept set and clear
    wire [NPINS-1:0] out_ok   = ~alt_mask & dir_q;
    wire [NPINS-1:0] set_bits = wr_set ? (REG_WDATA_I[NPINS-1:0] & out_ok)
                                       : '0;
    wire [NPINS-1:0] clr_bits = wr_clear ? (REG_WDATA_I[NPINS-1:0] & out_ok)
                                         : '0;

    // -------------------------------------------------------------------
    // direction enable sources
    // -------------------------------------------------------------------
    logic de_tx;

    turnaround_timer u_turnaround (
        .clk_i      (CLK_I),
        .arst_n_i   (ARST_N_I),
        .ce_i       (CE_I),
        .tx_busy_i  (UART_I.tx_busy),
        .bit_tick_i (UART_I.bit_tick),
        .delay_i    (delay_q),
        .de_o       (de_tx)
    );

    // polarity applied once here so every enable pin agrees
    wire de_tx_lvl    = role_q.pol ? de_tx : ~de_tx;
    wire de_match_lvl = role_q.pol ? UART_I.addr_match
                                   : ~UART_I.addr_match;

    // -------------------------------------------------------------------
    // alternate role selection per pin
    // -------------------------------------------------------------------
    always_comb begin
        alt_mask = '0;
        alt_val  = '0;
        alt_oe   = '0;
        // pin five and the handshake pairs follow the three-bit field
        case (role_q.p5_role)
            P5_RTS_CTS: begin
                alt_mask[PIN_CTS]    = 1'b1;
                alt_mask[PIN_RTS_DE] = 1'b1;
                alt_val[PIN_RTS_DE]  = UART_I.rts_level;
                alt_oe[PIN_RTS_DE]   = 1'b1;
            end
            P5_DTR_DSR: begin
                alt_mask[PIN_DTR] = 1'b1;
                alt_mask[PIN_DSR] = 1'b1;
                alt_val[PIN_DTR]  = UART_I.dtr_level;
                alt_oe[PIN_DTR]   = 1'b1;
            end
            P5_DE_TX: begin
                alt_mask[PIN_RTS_DE] = 1'b1;
                alt_val[PIN_RTS_DE]  = de_tx_lvl;
                alt_oe[PIN_RTS_DE]   = 1'b1;
            end
            P5_DE_MATCH: begin
                alt_mask[PIN_RTS_DE] = 1'b1;
                alt_val[PIN_RTS_DE]  = de_match_lvl;
                alt_oe[PIN_RTS_DE]   = 1'b1;
            end
            default: ; // gpio, and reserved codes fall back to gpio
        endcase
        // pin seven only takes a role when the select bit is set
        if (role_q.p7_sel) begin
            case (role_q.p7_role)
                P7_DE_TX: begin
                    alt_mask[PIN_DE] = 1'b1;
                    alt_val[PIN_DE]  = de_tx_lvl;
                    alt_oe[PIN_DE]   = 1'b1;
                end
                P7_DE_MATCH: begin
                    alt_mask[PIN_DE] = 1'b1;
                    alt_val[PIN_DE]  = de_match_lvl;
                    alt_oe[PIN_DE]   = 1'b1;
                end
                default: ;
            endcase
        end
        if (role_q.clk_en) begin
            alt_mask[PIN_CLK] = 1'b1;
            alt_val[PIN_CLK]  = UART_I.clk_gen;
            alt_oe[PIN_CLK]   = 1'b1;
        end
        if (role_q.tx_tog) begin
            alt_mask[PIN_TXTOG] = 1'b1;
            alt_val[PIN_TXTOG]  = tx_tog_q;
            alt_oe[PIN_TXTOG]   = 1'b1;
        end
        if (role_q.rx_tog) begin
            alt_mask[PIN_RXTOG] = 1'b1;
            alt_val[PIN_RXTOG]  = rx_tog_q;
            alt_oe[PIN_RXTOG]   = 1'b1;
        end
    end

    // gpio pins use the direction register, alternate pins ignore it
    assign gpio_d = (gpio_q | set_bits) & ~clr_bits;
    assign pin_d  = (alt_mask & alt_val) | (~alt_mask & gpio_q);
    assign oe_d   = (alt_mask & alt_oe) | (~alt_mask & dir_q);

    // receiver sees idle while transmitting in half duplex
    assign flow_d.rx_data = (UART_I.half_duplex && UART_I.tx_busy)
                            ? 1'b1 : rx_s2_q;
    assign flow_d.cts     = pin_s2_q[PIN_CTS];
    assign flow_d.dsr     = pin_s2_q[PIN_DSR];

    // -------------------------------------------------------------------
    // read data, one cycle after the strobe
    // -------------------------------------------------------------------
    always_comb begin
        rdata_d = 16'h0000;
        if (REG_ADDR_I == OFS_TURNAROUND) begin
            rdata_d = {12'h000, delay_q};
        end else if (REG_ADDR_I == OFS_ROLE) begin
            rdata_d = {6'h00, role_q};
        end else if (REG_ADDR_I == OFS_DIR) begin
            rdata_d = {6'h00, dir_q};
        end else if (REG_ADDR_I == OFS_STATE) begin
            rdata_d = {6'h00, pin_s2_q}; // live pin levels, any role
        end
    end

    // -------------------------------------------------------------------
    // software registers; upper bits are not stored and read zero
    // -------------------------------------------------------------------
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            delay_q <= RST_TURNAROUND;
            role_q  <= role_reg_t'(RST_ROLE);
            dir_q   <= RST_DIR;
            gpio_q  <= RST_GPIO_OUT;
        end else if (CE_I) begin
            if (wr_delay) delay_q <= REG_WDATA_I[3:0];
            if (wr_role) role_q <= role_reg_t'(REG_WDATA_I[NPINS-1:0]);
            if (wr_dir) dir_q <= REG_WDATA_I[NPINS-1:0];
            gpio_q <= gpio_d;
        end
    end

    // activity toggles flip once per character
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            tx_tog_q <= 1'b0;
            rx_tog_q <= 1'b0;
        end else if (CE_I) begin
            tx_tog_q <= tx_tog_q ^ UART_I.tx_char;
            rx_tog_q <= rx_tog_q ^ UART_I.rx_char;
        end
    end

    // two-stage synchronisers for asynchronous pin inputs
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
            rx_s1_q  <= 1'b1;
            rx_s2_q  <= 1'b1;
        end else if (CE_I) begin
            pin_s1_q <= PIN_I;
            pin_s2_q <= pin_s1_q;
            rx_s1_q  <= RX_SERIAL_I;
            rx_s2_q  <= rx_s1_q;
        end
    end

    // registered outputs; cost one cycle of latency on every pin
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            PIN_O       <= '0;
            PIN_OE_O    <= '0;
            FLOW_O      <= '{cts: 1'b0, dsr: 1'b0, rx_data: 1'b1};
            REG_RDATA_O <= 16'h0000;
        end else if (CE_I) begin
            PIN_O    <= pin_d;
            PIN_OE_O <= oe_d;
            FLOW_O   <= flow_d;
            if (REG_RD_I) REG_RDATA_O <= rdata_d;
        end
    end

    // -------------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------------
    a_set_drives_high: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        (CE_I && set_bits != '0) |=> ((gpio_q & $past(set_bits)) == $past(set_bits)))
        else $error("set bit did not drive output high");

    a_set_masked_pins: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        (CE_I && wr_set) |=> ((gpio_q & ~$past(out_ok)) == ($past(gpio_q) & ~$past(out_ok))))
        else $error("set touched an input or alternate pin");

    a_clear_drives_low: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        (CE_I && clr_bits != '0) |=> ((gpio_q & $past(clr_bits)) == '0))
        else $error("clear bit did not drive output low");

    a_pin5_polarity: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        (CE_I && role_q.p5_role == P5_DE_TX)
        |=> (PIN_O[PIN_RTS_DE] == ($past(role_q.pol) ? $past(de_tx) : !$past(de_tx))))
        else $error("pin five enable has wrong polarity");

    a_pin7_gpio_unsel: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        (CE_I && !role_q.p7_sel)
        |=> (PIN_O[PIN_DE] == $past(gpio_q[PIN_DE]) && PIN_OE_O[PIN_DE] == $past(dir_q[PIN_DE])))
        else $error("pin seven not gpio while unselected");

    a_pin7_match_en: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        (CE_I && role_q.p7_sel && role_q.p7_role == P7_DE_MATCH && role_q.pol
         && UART_I.addr_match) |=> (PIN_O[PIN_DE] && PIN_OE_O[PIN_DE]))
        else $error("pin seven not asserted on address match");

    a_tx_toggle_pin: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        (CE_I && role_q.tx_tog && UART_I.tx_char)
        ##1 (CE_I && role_q.tx_tog) |=> (PIN_O[PIN_TXTOG] != $past(PIN_O[PIN_TXTOG])))
        else $error("transmit toggle pin did not flip");

    a_clk_pin_drive: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        (CE_I && role_q.clk_en) |=> (PIN_OE_O[PIN_CLK] && PIN_O[PIN_CLK] == $past(UART_I.clk_gen)))
        else $error("clock not routed to pin six");

    a_rx_half_gate: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        (CE_I && UART_I.half_duplex && UART_I.tx_busy) |=> FLOW_O.rx_data)
        else $error("receive data passed while transmitting");

    a_read_role: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        (CE_I && REG_RD_I && REG_ADDR_I == OFS_ROLE) |=> (REG_RDATA_O == {6'h00, $past(role_q)}))
        else $error("role readback mismatch");

    c_set_then_clear: cover property (@(posedge CLK_I) disable iff (!ARST_N_I)
        (set_bits != '0) ##[1:20] (clr_bits != '0));

    c_de_on_pin7: cover property (@(posedge CLK_I) disable iff (!ARST_N_I)
        role_q.p7_sel && role_q.p7_role == P7_DE_TX && de_tx);

    c_rts_flow: cover property (@(posedge CLK_I) disable iff (!ARST_N_I)
        role_q.p5_role == P5_RTS_CTS && UART_I.tx_busy);

endmodule : pin_function_ctrl

`default_nettype wire

// >>> verif/board_model.sv
// board side of the ten pins: pull-ups plus an external driver
// assumes pin outputs and enables from the block are registered levels
`timescale 1ns/1ps
`default_nettype none

module board_model (
    input  wire logic [9:0] pin_o_i,
    input  wire logic [9:0] pin_oe_i,
    input  wire logic [9:0] ext_val_i,
    input  wire logic [9:0] ext_en_i,
    output var  logic [9:0] pin_lvl_o
);
    // ---------------------------------------------------------------
    // wire resolution
    // ---------------------------------------------------------------
    // a released pin takes the external driver when enabled, else the pull-up, never its last driven value
    always_comb begin
        for (int b = 0; b < 10; b++) begin
            pin_lvl_o[b] = pin_oe_i[b] ? pin_o_i[b] : (ext_en_i[b] ? ext_val_i[b] : 1'b1);
        end
    end
endmodule : board_model

`default_nettype wire

// >>> verif/test_pin_function_ctrl.sv
// self-checking bench for the pin function and gpio block
// assumes the block answers reads one cycle after the strobe
`timescale 1ns/1ps
`default_nettype none

module test_pin_function_ctrl;
    import pinfn_pkg::*;
    logic       clk, arst_n, wr_s, rd_s, rx_ser, ce;
    logic [4:0] roles_seen;
    logic [7:0] addr;
    logic [15:0] wdata, rdata;
    logic [9:0] pin_in, pin_out, pin_oe, ext_val, ext_en;
    uart_side_t uart;
    flow_side_t flow;
    int         miscompares = 0;
    int         comparisons = 0;

    pin_function_ctrl u_dut (.CLK_I(clk), .ARST_N_I(arst_n), .CE_I(ce), .REG_ADDR_I(addr),
        .REG_WDATA_I(wdata), .REG_WR_I(wr_s), .REG_RD_I(rd_s), .REG_RDATA_O(rdata),
        .UART_I(uart), .FLOW_O(flow), .RX_SERIAL_I(rx_ser), .PIN_I(pin_in),
        .PIN_O(pin_out), .PIN_OE_O(pin_oe));
    board_model u_board (.pin_o_i(pin_out), .pin_oe_i(pin_oe), .ext_val_i(ext_val),
        .ext_en_i(ext_en), .pin_lvl_o(pin_in));

    // handshake pin roles packed in table order: oe4, oe3, pin7, pin5, pin2
    assign roles_seen = {pin_oe[4:3], pin_out[7], pin_out[5], pin_out[2]};

    // ---------------------------------------------------------------
    // clock, watchdog and shared tasks
    // ---------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // a hang counts as a miscompare rather than a silent stall
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        complete_run();
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr_s  <= 1'b1;
        @(posedge clk);
        wr_s  <= 1'b0;
    endtask : wr

    // read data stand from the cycle after the strobe until the next read
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        check(rdata, exp);
    endtask : rd

    // transmit burst, then count bit ticks until the enable returns
    task automatic de_run(input int pin, input logic [15:0] role, input logic [3:0] d);
        wr(OFS_TURNAROUND, {12'h0, d});
        wr(OFS_ROLE, role);
        uart.tx_busy <= 1'b1;
        cyc(4);
        check(16'(pin_out[pin]), 16'(role[3]));
        @(posedge clk);
        uart.tx_busy <= 1'b0;
        for (int k = 0; k < d; k++) begin
            cyc(3);
            check(16'(pin_out[pin]), 16'(role[3]));
            @(posedge clk);
            uart.bit_tick <= 1'b1;
            @(posedge clk);
            uart.bit_tick <= 1'b0;
        end
        cyc(3);
        check(16'(pin_out[pin]), 16'(!role[3]));
    endtask : de_run

    task automatic complete_run;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : complete_run

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        logic [15:0] rl [5] = '{16'h001, 16'h002, 16'h00c, 16'h058, 16'h048};
        logic [4:0]  ex [5] = '{5'h0a, 5'h11, 5'h1a, 5'h1c, 5'h18};
        arst_n = 1'b0; addr = '0; wdata = '0; wr_s = 1'b0; rd_s = 1'b0; rx_ser = 1'b1;
        ce = 1'b1;
        uart = '0; ext_val = '0; ext_en = '0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        rd(OFS_ROLE, 16'h0300);
        rd(OFS_TURNAROUND, 16'h0000);
        rd(OFS_DIR, 16'h0000);
        rd(OFS_SET, 16'h0000);
        rd(8'h20, 16'h0000);
        check(16'(pin_oe), 16'h0300);
        $display("test reset values done");
        wr(OFS_ROLE, 16'h0000);
        wr(OFS_DIR, 16'h00ff);
        wr(OFS_SET, 16'h03ff);
        cyc(2);
        check(16'(pin_oe), 16'h00ff);
        check(16'(pin_out & pin_oe), 16'h00ff);
        wr(OFS_CLEAR, 16'h000f);
        cyc(5);
        check(16'(pin_out & pin_oe), 16'h00f0);
        rd(OFS_STATE, 16'h03f0);
        wr(OFS_DIR, 16'h03ff);
        cyc(2);
        check(16'(pin_out[9:8]), 16'h0);
        $display("test gpio done");
        wr(OFS_ROLE, 16'h0080);
        wr(OFS_CLEAR, 16'h0040);
        cyc(3);
        check(16'(pin_out[6]), 16'h0);
        @(posedge clk);
        uart.clk_gen <= 1'b1;
        wr(OFS_CLEAR, 16'h0040);
        cyc(3);
        check(16'(pin_out[6]), 16'h1);
        wr(OFS_ROLE, 16'h0300);
        wr(OFS_CLEAR, 16'h03ff);
        for (int k = 1; k <= 2; k++) begin
            @(posedge clk);
            uart.tx_char <= 1'b1;
            uart.rx_char <= (k == 1);
            @(posedge clk);
            uart.tx_char <= 1'b0;
            uart.rx_char <= 1'b0;
            cyc(2);
            check(16'(pin_out[9:8]), (k == 1) ? 16'h3 : 16'h2);
        end
        $display("test clock and toggles done");
        @(posedge clk);
        uart.rts_level <= 1'b1;
        uart.dtr_level <= 1'b1;
        uart.addr_match <= 1'b1;
        for (int k = 0; k < 5; k++) begin
            wr(OFS_ROLE, rl[k]);
            // four edges: pin register, two sync stages, flow register
            cyc(4);
            check(16'(roles_seen), 16'(ex[k]));
            // released handshake inputs read the pull-up, driven ones read low
            check(16'({flow.cts, flow.dsr}), 16'(ex[k][4:3] ^ 2'b11));
        end
        @(posedge clk);
        uart.addr_match <= 1'b0;
        de_run(5, 16'h000b, 4'h2);
        de_run(5, 16'h0003, 4'hf);
        de_run(5, 16'h000b, 4'h0);
        de_run(7, 16'h0038, 4'h3);
        $display("test direction enable done");
        // a write while the block is frozen must not land
        @(posedge clk);
        ce <= 1'b0;
        wr(OFS_DIR, 16'h0000);
        ce <= 1'b1;
        rd(OFS_DIR, 16'h03ff);
        $display("test clock enable done");
        @(posedge clk);
        uart.half_duplex <= 1'b1;
        uart.tx_busy <= 1'b1;
        rx_ser <= 1'b0;
        cyc(4);
        check(16'(flow.rx_data), 16'h1);
        @(posedge clk);
        uart.tx_busy <= 1'b0;
        cyc(4);
        check(16'(flow.rx_data), 16'h0);
        $display("test half duplex done");
        complete_run();
    end
endmodule : test_pin_function_ctrl

`default_nettype wire
